/* File: pkg/hsl_pkg.sv */
// Package of constants and carrier types for the hub strap sampler
package hsl_pkg;
  // Port count, fixed for the four-port variant
  localparam int unsigned NUM_PORTS = 4;
  // Configuration method encoding {hi, lo}
  localparam logic [1:0] CFG_DEFAULT = 2'h0;
  localparam logic [1:0] CFG_SMBUS = 2'h1;
  localparam logic [1:0] CFG_BUS_PWR = 2'h2;
  localparam logic [1:0] CFG_EEPROM = 2'h3;
  // Fixed-port strap decode
  localparam logic [1:0] FIX_NONE = 2'h0;
  localparam logic [1:0] FIX_P1 = 2'h1;
  localparam logic [1:0] FIX_P12 = 2'h2;
  localparam logic [1:0] FIX_P123 = 2'h3;
  // Reset values
  localparam logic [1:0] RST_CFG = 2'h0;
  localparam logic [1:0] RST_FIX = 2'h0;
  localparam logic [NUM_PORTS-1:0] RST_CHG = 4'h0;
  // Strap inputs sampled at reset release
  typedef struct packed {
    logic cfg_hi;
    logic cfg_lo;
    logic [1:0] fixed_port_strap_pair;
    logic [NUM_PORTS-1:0] charge_enable_straps;
  } hsl_straps_t;
  // Captured configuration held until the next reset
  typedef struct packed {
    logic [1:0] cfg_method;
    logic straps_enabled;
    logic [1:0] fixed_code;
    logic [NUM_PORTS-1:0] fixed_ports;
    logic compound;
    logic [NUM_PORTS-1:0] charge_enable;
    logic led_lo_active_low;
    logic bus_powered_cfg;
  } hsl_config_t;
  // Hub link state feeding the indicators
  typedef struct packed {
    logic connected;
    logic high_speed;
    logic configured;
    logic suspended;
  } hsl_link_t;
  // Sampler states, one-hot
  typedef enum logic [2:0] {
    HSL_ST_RESET = 3'h1,
    HSL_ST_CAPTURE = 3'h2,
    HSL_ST_HOLD = 3'h4
  } hsl_state_t;
endpackage

/* File: hw/hsl_fixed_decode.sv */
// Decoder of the fixed-port strap pair into a per-port mask
`timescale 1ns/1ps
module hsl_fixed_decode
  import hsl_pkg::*;
(
  input wire logic [1:0] code_i,
  output logic [hsl_pkg::NUM_PORTS-1:0] fixed_o
);
  always_comb
  begin
    case (code_i)
      FIX_NONE: fixed_o = 4'h0;
      FIX_P1: fixed_o = 4'h1;
      FIX_P12: fixed_o = 4'h3;
      FIX_P123: fixed_o = 4'h7;
      default: fixed_o = 4'h0;
    endcase
  end
endmodule

/* File: hw/hsl_led_drive.sv */
// Indicator pin driver with strap-selected polarity
`timescale 1ns/1ps
module hsl_led_drive
(
  input wire logic lit_i,
  input wire logic active_low_i,
  input wire logic sampling_i,
  output logic pin_o,
  output logic pin_oe_o
);
  // Pin released while strap level is sampled, so the resistor sets it
  assign pin_o = lit_i ^ active_low_i;
  assign pin_oe_o = ~sampling_i;
endmodule

/* File: hw/hsl_strap_core.sv */
// Strap sampling and status indicator logic of the hub
`timescale 1ns/1ps
// Overview of operation
// - High-speed indicator on when upstream is at high speed, off at full speed.
// - Latch both configuration-select straps at reset release to pick config method.
// - Active/suspend indicator on only when configured and not suspended.
// - Local-power detect low means bus power only, high means local power.
// - With straps enabled, sample both fixed-port strap bits together one cycle after release, once the method is latched.
// - Fixed-port code 00 none, 01 port 1, 10 ports 1-2, 11 ports 1-3.
// - LED on low fixed-port pin active high if strap 0, active low if 1.
// - LED polarity of shared strap pins comes from the sampled strap value; the low fixed-port pin stays active high with straps disabled.
// - Strap levels honoured only when the config method enables straps.
// - Pin high samples as option 1, pin low as option 0.
// - Pull-down pins read option 0 when nothing pulls them high.
// - Charge enables sampled from port power pins, one bit per port.
// - Charge enable strap 1 enables charging on that port, 0 disables.
// - Any fixed port makes the hub report itself as a compound device.
// - SMBus or EEPROM configuration disables all strap options.
module hsl_strap_core
  import hsl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire hsl_pkg::hsl_straps_t straps_i,
  input wire hsl_pkg::hsl_link_t link_i,
  input wire logic local_power_detect_i,
  input wire logic [hsl_pkg::NUM_PORTS-1:0] port_power_req_i,
  output logic high_speed_indicator_o,
  output logic high_speed_indicator_oe_o,
  output logic active_suspend_indicator_o,
  output logic active_suspend_indicator_oe_o,
  output logic [hsl_pkg::NUM_PORTS-1:0] port_power_outputs_o,
  output logic [hsl_pkg::NUM_PORTS-1:0] port_power_outputs_oe_o,
  output hsl_pkg::hsl_config_t config_o,
  output logic config_valid_o,
  output logic self_powered_o
);
  import hsl_pkg::*;

  // ==========================================================
  // Sampler state
  hsl_state_t state_ff;
  hsl_state_t nxt_state;
  logic [1:0] cfg_ff;
  logic [1:0] nxt_cfg;
  logic [1:0] fix_ff;
  logic [1:0] nxt_fix;
  logic [NUM_PORTS-1:0] chg_ff;
  logic [NUM_PORTS-1:0] nxt_chg;
  logic strap_en;
  logic sampling;
  logic [NUM_PORTS-1:0] fixed_mask;

  // Config method decides whether strap levels count
  assign strap_en = (cfg_ff == CFG_DEFAULT) || (cfg_ff == CFG_BUS_PWR);
  assign sampling = (state_ff != HSL_ST_HOLD);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cfg = cfg_ff;
    nxt_fix = fix_ff;
    nxt_chg = chg_ff;
    case (state_ff)
      HSL_ST_RESET:
      begin
        // Straps read as plain levels: high is 1, low or pulled-down is 0
        nxt_cfg = {straps_i.cfg_hi, straps_i.cfg_lo};
        nxt_state = HSL_ST_CAPTURE;
      end
      HSL_ST_CAPTURE:
      begin
        // Method known one cycle before the other straps are honoured
        if (strap_en)
        begin
          nxt_fix = straps_i.fixed_port_strap_pair;
          nxt_chg = straps_i.charge_enable_straps;
        end
        else
        begin
          nxt_fix = RST_FIX;
          nxt_chg = RST_CHG;
        end
        nxt_state = HSL_ST_HOLD;
      end
      HSL_ST_HOLD:
      begin
        nxt_state = HSL_ST_HOLD;
      end
      default:
      begin
        nxt_state = HSL_ST_RESET;
      end
    endcase
  end

  // Reset held as the strap window; release is the sampling moment
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= HSL_ST_RESET;
      fix_ff <= RST_FIX;
      chg_ff <= RST_CHG;
      cfg_ff <= RST_CFG;
    end
    else
    begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      fix_ff <= nxt_fix;
      chg_ff <= nxt_chg;
    end
  end

  // ==========================================================
  // Derived configuration
  hsl_fixed_decode u_fixed_decode
  (
    .code_i(fix_ff),
    .fixed_o(fixed_mask)
  );

  always_comb
  begin
    config_o.cfg_method = cfg_ff;
    config_o.straps_enabled = strap_en;
    config_o.fixed_code = fix_ff;
    config_o.fixed_ports = fixed_mask;
    config_o.compound = (fix_ff != FIX_NONE);
    config_o.charge_enable = chg_ff;
    config_o.led_lo_active_low = fix_ff[0];
    config_o.bus_powered_cfg = (cfg_ff == CFG_BUS_PWR);
  end

  assign config_valid_o = (state_ff == HSL_ST_HOLD);
  // Low means all power from upstream bus
  assign self_powered_o = local_power_detect_i;

  // ==========================================================
  // Indicators
  logic hs_lit;
  logic act_lit;
  logic act_pol;
  logic hs_pol;
  assign hs_lit = link_i.connected & link_i.high_speed;
  // High-speed pin doubles as the upper select strap, so it follows that level
  assign hs_pol = config_valid_o & cfg_ff[1];
  assign act_lit = link_i.configured & ~link_i.suspended;
  // Polarity only meaningful once the strap is held
  assign act_pol = config_valid_o & fix_ff[0];

  hsl_led_drive u_hs_led
  (
    .lit_i(hs_lit),
    .active_low_i(hs_pol),
    .sampling_i(sampling),
    .pin_o(high_speed_indicator_o),
    .pin_oe_o(high_speed_indicator_oe_o)
  );

  hsl_led_drive u_act_led
  (
    .lit_i(act_lit),
    .active_low_i(act_pol),
    .sampling_i(sampling),
    .pin_o(active_suspend_indicator_o),
    .pin_oe_o(active_suspend_indicator_oe_o)
  );

  // Port power pins released during sampling so the pull-downs set the strap
  assign port_power_outputs_o = config_valid_o ? (port_power_req_i | chg_ff) : 4'h0;
  assign port_power_outputs_oe_o = {NUM_PORTS{config_valid_o}};

  // ==========================================================
  // Per-port checks
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    chk_port_charge: assert property (@(posedge clk_i) disable iff (rst_i)
      (config_valid_o && chg_ff[p]) |-> port_power_outputs_o[p])
      else $error("charging port not powered");

    // Host request alone may still power a port that is not charging
    chk_port_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      (config_valid_o && !chg_ff[p] && !port_power_req_i[p]) |-> !port_power_outputs_o[p])
      else $error("idle port powered");

    chk_port_oe: assert property (@(posedge clk_i) disable iff (rst_i)
      port_power_outputs_oe_o[p] == config_valid_o)
      else $error("port power pin drive wrong");

    chk_chg_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_ff == HSL_ST_CAPTURE)
      |=> (chg_ff[p] == ($past(strap_en) & $past(straps_i.charge_enable_straps[p]))))
      else $error("charge strap bit wrong");
  end

  // ==========================================================
  // Checks on capture
  chk_cfg_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |=> (cfg_ff == $past({straps_i.cfg_hi, straps_i.cfg_lo})))
    else $error("config select not latched at release");

  chk_capture_start: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (state_ff == HSL_ST_RESET))
    else $error("sampler not at start after release");

  chk_valid_timing: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (!config_valid_o ##1 !config_valid_o ##1 config_valid_o))
    else $error("config valid at wrong edge");

  chk_capture_next: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == HSL_ST_CAPTURE) |=> config_valid_o)
    else $error("capture did not end in hold");

  chk_fix_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == HSL_ST_CAPTURE && strap_en)
    |=> (fix_ff == $past(straps_i.fixed_port_strap_pair)))
    else $error("fixed-port straps not sampled");

  chk_chg_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == HSL_ST_CAPTURE && strap_en) |=> (chg_ff == $past(straps_i.charge_enable_straps)))
    else $error("charge strap not sampled");

  chk_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == HSL_ST_CAPTURE && !strap_en) |=> (fix_ff == RST_FIX && chg_ff == RST_CHG))
    else $error("straps captured while disabled");

  chk_strap_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (config_valid_o && !strap_en) |-> (fix_ff == 2'h0 && chg_ff == 4'h0))
    else $error("straps honoured while disabled");

  // Method bit 0 alone selects an external configuration source
  chk_strap_method: assert property (@(posedge clk_i) disable iff (rst_i)
    config_o.straps_enabled == !config_o.cfg_method[0])
    else $error("strap enable does not follow method");

  chk_strap_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (config_valid_o && !config_o.straps_enabled) |-> !config_o.compound)
    else $error("compound set with straps disabled");

  chk_bus_pwr_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    config_o.bus_powered_cfg |-> config_o.straps_enabled)
    else $error("bus-powered method lost its straps");

  chk_hold_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    (config_valid_o && $past(config_valid_o)) |-> $stable(config_o))
    else $error("held config changed");

  chk_hold_state: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == HSL_ST_HOLD) |=> (state_ff == HSL_ST_HOLD))
    else $error("sampler left hold without reset");

  chk_state_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot(state_ff))
    else $error("sampler state not one-hot");

  // ==========================================================
  // Checks on derived values
  chk_fix_none: assert property (@(posedge clk_i) disable iff (rst_i)
    (fix_ff == FIX_NONE) |-> (config_o.fixed_ports == 4'h0))
    else $error("fixed port decode wrong for none");

  chk_fix_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (fix_ff == FIX_P1) |-> (config_o.fixed_ports == 4'h1))
    else $error("fixed port decode wrong for one port");

  chk_fix_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (fix_ff == 2'h2) |-> (config_o.fixed_ports == 4'h3))
    else $error("fixed port decode wrong");

  chk_fix_three: assert property (@(posedge clk_i) disable iff (rst_i)
    (fix_ff == FIX_P123) |-> (config_o.fixed_ports == 4'h7))
    else $error("fixed port decode wrong for three ports");

  chk_compound_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    config_o.compound == (config_o.fixed_ports != 4'h0))
    else $error("compound flag wrong");

  // ==========================================================
  // Checks on pins
  chk_hs_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    config_valid_o |-> ((high_speed_indicator_o ^ cfg_ff[1])
      == (link_i.connected & link_i.high_speed)))
    else $error("high-speed indicator wrong");

  chk_hs_fs: assert property (@(posedge clk_i) disable iff (rst_i)
    (config_valid_o && link_i.connected && !link_i.high_speed)
    |-> (high_speed_indicator_o == cfg_ff[1]))
    else $error("high-speed indicator lit at full speed");

  chk_hs_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (config_valid_o && !link_i.connected) |-> (high_speed_indicator_o == cfg_ff[1]))
    else $error("high-speed indicator lit while unconnected");

  chk_act_ind: assert property (@(posedge clk_i) disable iff (rst_i)
    config_valid_o |-> ((active_suspend_indicator_o ^ fix_ff[0])
      == (link_i.configured & ~link_i.suspended)))
    else $error("active indicator wrong");

  chk_as_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (config_valid_o && !link_i.configured) |-> (active_suspend_indicator_o == fix_ff[0]))
    else $error("active indicator lit while unconfigured");

  chk_as_pol_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (config_valid_o && !strap_en) |-> (active_suspend_indicator_o == act_lit))
    else $error("active indicator inverted with straps disabled");

  chk_pwr_detect: assert property (@(posedge clk_i) disable iff (rst_i)
    self_powered_o == local_power_detect_i)
    else $error("local power detect wrong");

  // Released pins let the resistors set the strap level
  chk_oe_release: assert property (@(posedge clk_i) disable iff (rst_i)
    !config_valid_o |-> !(high_speed_indicator_oe_o || active_suspend_indicator_oe_o
      || (|port_power_outputs_oe_o)))
    else $error("pin driven while straps sampled");

  chk_pins_driven: assert property (@(posedge clk_i) disable iff (rst_i)
    config_valid_o |-> (high_speed_indicator_oe_o && active_suspend_indicator_oe_o))
    else $error("indicator pin not driven after capture");
endmodule

/* File: tb/hsl_board.sv */
// Board model: strap resistors, active/suspend LED and local supply detector
`timescale 1ns/1ps
module hsl_board
(
  input wire logic [7:0] pull_up_i,
  input wire logic supply_i,
  input wire logic led_pin_i,
  input wire logic led_oe_i,
  output hsl_pkg::hsl_straps_t straps_o,
  output logic local_power_detect_o,
  output logic led_lit_o
);
  import hsl_pkg::*;
  // ==========================================================
  // Straps: a fitted pull-up reads 1, otherwise the pull-down wins
  assign straps_o = hsl_straps_t'(pull_up_i);
  assign local_power_detect_o = supply_i;
  // LED to supply when the low fixed strap is pulled up, so lit on a low pin
  assign led_lit_o = led_oe_i & (led_pin_i ^ pull_up_i[4]);
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the hub strap sampler
`timescale 1ns/1ps
module tb;
  import hsl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] pull = 8'h00;
  logic supply = 1'b0;
  hsl_link_t link = '0;
  logic [NUM_PORTS-1:0] req = '0;
  hsl_straps_t straps;
  hsl_config_t cfg;
  logic lpd, hs, hs_oe, as, as_oe, valid, selfp, lit;
  logic [NUM_PORTS-1:0] pp, pp_oe;
  int err_count = 0;
  int samples_checked = 0;
  // ==========================================================
  // Clock stands in for the board reference
  always #2.5 clk_i = ~clk_i;
  hsl_strap_core dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .straps_i(straps), .link_i(link),
    .local_power_detect_i(lpd), .port_power_req_i(req),
    .high_speed_indicator_o(hs), .high_speed_indicator_oe_o(hs_oe),
    .active_suspend_indicator_o(as), .active_suspend_indicator_oe_o(as_oe),
    .port_power_outputs_o(pp), .port_power_outputs_oe_o(pp_oe),
    .config_o(cfg), .config_valid_o(valid), .self_powered_o(selfp));
  hsl_board board_u (
    .pull_up_i(pull), .supply_i(supply), .led_pin_i(as), .led_oe_i(as_oe),
    .straps_o(straps), .local_power_detect_o(lpd), .led_lit_o(lit));
  // ==========================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  // Pins stay released while sampling; bounded wait for capture
  task automatic restart(input logic [7:0] p);
    int n;
    pull = p;
    rst_i = 1'b1;
    repeat (8) step();
    chk("oe_in_reset", 16'h0, 16'({hs_oe, as_oe, pp_oe, valid}));
    rst_i = 1'b0;
    n = 0;
    while (valid !== 1'b1 && n < 8)
    begin
      step();
      n++;
    end
    chk("valid_edge", 16'h2, 16'(n));
    if (n == 8) give_verdict();
  endtask
  task automatic expect_cfg(input logic [7:0] p);
    logic [1:0] m, f;
    logic en;
    logic [3:0] c, mask;
    m = p[7:6];
    en = (m == CFG_DEFAULT) || (m == CFG_BUS_PWR);
    f = en ? p[5:4] : 2'h0;
    c = en ? p[3:0] : 4'h0;
    mask = (f == FIX_P1) ? 4'h1 : (f == FIX_P12) ? 4'h3 : (f == FIX_P123) ? 4'h7 : 4'h0;
    chk("cfg_method", 16'(m), 16'(cfg.cfg_method));
    chk("straps_en", 16'(en), 16'(cfg.straps_enabled));
    chk("fixed", 16'({f, mask}), 16'({cfg.fixed_code, cfg.fixed_ports}));
    chk("compound", 16'(f != 2'h0), 16'(cfg.compound));
    chk("charge", 16'(c), 16'(cfg.charge_enable));
    chk("led_pol", 16'(f[0]), 16'(cfg.led_lo_active_low));
    chk("bus_pwr", 16'(m == CFG_BUS_PWR), 16'(cfg.bus_powered_cfg));
    req = 4'h0;
    step();
    chk("port_power", 16'({4'hf, c}), 16'({pp_oe, pp}));
    req = 4'ha;
    step();
    chk("port_req", 16'(c | 4'ha), 16'(pp));
  endtask
  task automatic t_capture(input logic [7:0] p);
    restart(p);
    expect_cfg(p);
  endtask
  // Strap changes after capture must not leak through
  task automatic t_hold(input logic [7:0] p);
    restart(p);
    pull = ~p;
    repeat (3) step();
    expect_cfg(p);
    pull = p;
  endtask
  // Every link state, with the LED polarity of the current straps
  task automatic t_leds();
    logic on, lo_pol, hs_pol;
    lo_pol = pull[4] & ~pull[6];
    hs_pol = pull[7];
    for (int i = 0; i < 16; i++)
    begin
      link = hsl_link_t'(4'(i));
      step();
      on = i[1] & ~i[0];
      chk("high_speed_indicator", 16'({1'b1, (i[3] & i[2]) ^ hs_pol}), 16'({hs_oe, hs}));
      chk("as_pin", 16'({1'b1, on ^ lo_pol}), 16'({as_oe, as}));
      chk("as_lit", 16'(on ^ lo_pol ^ pull[4]), 16'(lit));
    end
  endtask
  task automatic t_power();
    for (int v = 0; v < 2; v++)
    begin
      supply = v[0];
      step();
      chk("self_pwr", 16'(v[0]), 16'(selfp));
    end
  endtask
  // ==========================================================
  logic [7:0] cases [4] = '{8'h00, 8'hbf, 8'h7f, 8'hff};
  initial
  begin
    t_capture(8'h15);
    t_leds();
    t_capture(8'h2a);
    t_leds();
    for (int k = 0; k < 4; k++) t_capture(cases[k]);
    t_leds();
    t_hold(8'h9e);
    t_leds();
    t_power();
    give_verdict();
  end
endmodule
